// *** rtl/pds_pkg.sv ***
/*
 parameter dictionary store: shared constants for index decode, the
 suppression code word and the channel block layout.
 assumes a single 25 MHz logic clock and a synchronous reset.
*/
package pds_pkg;
   localparam logic [15:0] SUPPRESS_IDX   = 16'hF008;
   localparam logic [31:0] SUPPRESS_CODE  = 32'h1234_5678;
   localparam logic [31:0] SUPPRESS_RST   = 32'h0000_0000;
   localparam logic [11:0] CHAN_BASE_HI   = 12'h800;
   localparam int          CHAN_IDX_BITS  = 4;
   localparam logic [7:0]  SUB_MAX        = 8'hFF;
   localparam int          CLK_PERIOD_NS  = 40;
endpackage : pds_pkg

// *** rtl/pds_store.sv ***
/*
 parameter dictionary store: per-channel parameter words addressed by a
 16-bit index and 8-bit subindex, a suppression code word entry, and a
 nonvolatile commit request that writes made while suppression holds never raise.
 assumes the mailbox side keeps a request up for one cycle and that the
 nonvolatile writer acknowledges each commit with NV_DONE.
*/
// Function
// R1: entries addressed by 16-bit index, 8-bit subindex
// R2: modified writable parameters committed to nonvolatile memory; a pending change is dropped when a newer write overwrites it
// R3: code word at entry sets suppressed mode
// R4: suppression holds while entry keeps code word
// R5: suppression inactive after every power-on
// R6: suppressed writes update live values, never commit
// R7: master avoids endless writes without suppression
// R8: channel n spans indices 0x80n0 to 0x80nF
// R9: master replays startup list if no retention
// R10: live update immediate, commit never blocks mailbox
`timescale 1ns/1ps
module pds_store #(
   parameter int CHANNELS = 4,   // channel parameter blocks
   parameter int SUBS     = 4    // stored subindices per index
) (
   input  wire logic        CLK,        // 25 MHz logic clock
   input  wire logic        SYS_RST,    // power-on reset, high
   input  wire logic        MB_REQ,     // mailbox access strobe
   input  wire logic        MB_WR,      // 1 write, 0 read
   input  wire logic [15:0] MB_INDEX,   // main index
   input  wire logic [7:0]  MB_SUB,     // subindex
   input  wire logic [31:0] MB_WDATA,   // write value
   output logic             MB_ACK,     // access answered
   output logic             MB_ERR,     // entry not present
   output logic [31:0]      MB_RDATA,   // read value
   output logic             NV_REQ,     // commit request level
   output logic [15:0]      NV_INDEX,   // committed index
   output logic [7:0]       NV_SUB,     // committed subindex
   output logic [31:0]      NV_DATA,    // committed value
   input  wire logic        NV_DONE,    // commit finished pulse
   output logic             NV_SUPPRESS // suppression active
);
   localparam int NWORDS = CHANNELS * 16 * SUBS;
   localparam int AW     = $clog2(NWORDS);

   logic [31:0] mem_q [NWORDS];
   logic [31:0] mem_d [NWORDS];
   logic [31:0] code_q, code_d;
   logic        ack_q, ack_d, err_q, err_d;
   logic [31:0] rdata_q, rdata_d;
   logic        nvr_q, nvr_d, pend_q, pend_d;
   logic [15:0] nvi_q, nvi_d, pi_q, pi_d;
   logic [7:0]  nvs_q, nvs_d, ps_q, ps_d;
   logic [31:0] nvv_q, nvv_d, pv_q, pv_d;
   logic        hit_ch, hit_code;
   logic [AW-1:0] widx;
   logic        sup_q, sup_d;

   // channel block decode: 0x80n0..0x80nF, low subindices stored
   function automatic logic chan_hit(input logic [15:0] idx,
                                     input logic [7:0] sub);
      chan_hit = (idx[15:8] == pds_pkg::CHAN_BASE_HI[11:4])
               && (32'(idx[7:4]) < CHANNELS)
               && (32'(sub) < SUBS); // R8
   endfunction : chan_hit

   function automatic logic [AW-1:0] word_of(input logic [15:0] idx,
                                             input logic [7:0] sub);
      word_of = AW'((32'(idx[7:0]) * SUBS) + 32'(sub)); // R1
   endfunction : word_of

   assign hit_ch   = chan_hit(MB_INDEX, MB_SUB);
   assign hit_code = (MB_INDEX == pds_pkg::SUPPRESS_IDX) && (MB_SUB == 8'h00);
   assign widx     = word_of(MB_INDEX, MB_SUB);

   always_comb
   begin
      mem_d   = mem_q;
      code_d  = code_q;
      ack_d   = MB_REQ;
      err_d   = MB_REQ && !hit_ch && !hit_code;
      rdata_d = rdata_q;
      pend_d  = pend_q;
      pi_d    = pi_q;
      ps_d    = ps_q;
      pv_d    = pv_q;
      nvr_d   = nvr_q;
      nvi_d   = nvi_q;
      nvs_d   = nvs_q;
      nvv_d   = nvv_q;
      if (nvr_q && NV_DONE)
         nvr_d = 1'b0;
      // launch before this cycle's write so a fresh change waits its turn
      if (pend_q && !nvr_d)
      begin
         nvr_d  = 1'b1; // R10
         nvi_d  = pi_q;
         nvs_d  = ps_q;
         nvv_d  = pv_q;
         pend_d = 1'b0;
      end
      if (MB_REQ && !MB_WR)
      begin
         if (hit_code)
            rdata_d = code_q;
         else if (hit_ch)
            rdata_d = mem_q[widx];
         else
            rdata_d = 32'h0000_0000;
      end
      if (MB_REQ && MB_WR)
      begin
         if (hit_code)
            code_d = MB_WDATA; // R3 R4
         else if (hit_ch)
         begin
            mem_d[widx] = MB_WDATA; // R10
            // only the latest change waits; older ones are overwritten
            if (code_q != pds_pkg::SUPPRESS_CODE) // R6
            begin
               pend_d = 1'b1; // R2
               pi_d   = MB_INDEX;
               ps_d   = MB_SUB;
               pv_d   = MB_WDATA;
            end
         end
      end
      // flag follows the entry as it will stand after this edge
      sup_d   = (code_d == pds_pkg::SUPPRESS_CODE); // R3 R4
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         for (int i = 0; i < NWORDS; i++)
            mem_q[i] <= 32'h0000_0000;
         code_q  <= pds_pkg::SUPPRESS_RST; // R5
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         pend_q  <= 1'b0;
         pi_q    <= 16'h0000;
         ps_q    <= 8'h00;
         pv_q    <= 32'h0000_0000;
         nvr_q   <= 1'b0;
         nvi_q   <= 16'h0000;
         nvs_q   <= 8'h00;
         nvv_q   <= 32'h0000_0000;
         sup_q   <= 1'b0; // R5
      end
      else
      begin
         mem_q   <= mem_d;
         code_q  <= code_d;
         ack_q   <= ack_d;
         err_q   <= err_d;
         rdata_q <= rdata_d;
         pend_q  <= pend_d;
         pi_q    <= pi_d;
         ps_q    <= ps_d;
         pv_q    <= pv_d;
         nvr_q   <= nvr_d;
         nvi_q   <= nvi_d;
         nvs_q   <= nvs_d;
         nvv_q   <= nvv_d;
         sup_q   <= sup_d;
      end
   end

   assign MB_ACK      = ack_q;
   assign MB_ERR      = err_q;
   assign MB_RDATA    = rdata_q;
   assign NV_REQ      = nvr_q;
   assign NV_INDEX    = nvi_q;
   assign NV_SUB      = nvs_q;
   assign NV_DATA     = nvv_q;
   assign NV_SUPPRESS = sup_q;

   // every check below is off while SYS_RST holds, except the reset ones
   a_ack_follows: assert property ( // R10
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ |=> MB_ACK) else $error("request not acknowledged");
   a_idle_quiet: assert property ( // R10
      @(posedge CLK) disable iff (SYS_RST)
      !MB_REQ |=> !MB_ACK && !MB_ERR) else $error("answer without request");
   a_absent_zero: assert property ( // R1
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && !MB_WR && !hit_ch && !hit_code
      |=> MB_RDATA == 32'h0000_0000) else $error("absent read not zero");
   a_rdata_holds: assert property ( // R1
      @(posedge CLK) disable iff (SYS_RST)
      !(MB_REQ && !MB_WR) |=> $stable(MB_RDATA))
      else $error("read data moved without a read");
   a_code_sets: assert property ( // R3
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_WR && hit_code && MB_WDATA == pds_pkg::SUPPRESS_CODE
      |=> NV_SUPPRESS) else $error("code word did not suppress");
   a_sub_absent: assert property ( // R3
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_INDEX == pds_pkg::SUPPRESS_IDX && MB_SUB != 8'h00
      |=> MB_ERR) else $error("code entry subindex not refused");
   a_code_leaves: assert property ( // R4
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_WR && hit_code && MB_WDATA != pds_pkg::SUPPRESS_CODE
      |=> !NV_SUPPRESS) else $error("suppression not left");
   a_sup_holds: assert property ( // R4
      @(posedge CLK) disable iff (SYS_RST)
      NV_SUPPRESS && !(MB_REQ && MB_WR && hit_code) |=> NV_SUPPRESS)
      else $error("suppression dropped");
   a_reset_off: assert property ( // R5
      @(posedge CLK) $past(SYS_RST) |-> !NV_SUPPRESS)
      else $error("suppressed at reset");
   a_reset_quiet: assert property ( // R5
      @(posedge CLK) $past(SYS_RST) |-> !MB_ACK && !MB_ERR && !NV_REQ)
      else $error("outputs busy after reset");
   a_commit_req: assert property ( // R2
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_WR && hit_ch && !NV_SUPPRESS && !NV_REQ
      |-> ##[1:3] NV_REQ) else $error("no commit");
   a_nv_holds: assert property ( // R2
      @(posedge CLK) disable iff (SYS_RST)
      NV_REQ && !NV_DONE |=> NV_REQ && $stable(NV_INDEX)
      && $stable(NV_SUB) && $stable(NV_DATA))
      else $error("commit request changed before done");
   a_no_commit: assert property ( // R6
      @(posedge CLK) disable iff (SYS_RST)
      NV_SUPPRESS && !pend_q && !NV_REQ ##1 NV_SUPPRESS |-> !NV_REQ)
      else $error("commit while suppressed");
   a_live_read: assert property ( // R10
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_WR && hit_ch ##1 MB_REQ && !MB_WR && $stable(MB_INDEX)
      && $stable(MB_SUB) |=> MB_RDATA == $past(MB_WDATA, 2))
      else $error("live value stale");
   a_unmapped_err: assert property ( // R8
      @(posedge CLK) disable iff (SYS_RST)
      MB_REQ && MB_INDEX[15:8] != pds_pkg::CHAN_BASE_HI[11:4]
      && MB_INDEX != pds_pkg::SUPPRESS_IDX |=> MB_ERR)
      else $error("unmapped not flagged");
endmodule : pds_store

// *** test/pds_nv_model.sv ***
/*
 nonvolatile writer model: acknowledges each commit request DELAY+1
 cycles after it rises and counts the commits it took.
 assumes NV_REQ holds until the cycle after the NV_DONE pulse.
*/
`timescale 1ns/1ps
module pds_nv_model #(
   parameter int DELAY = 3 // cycles from the edge that sees the request to ack
) (
   input  wire logic CLK,     // logic clock
   input  wire logic SYS_RST, // sync reset, high
   input  wire logic NV_REQ,  // commit request level
   output logic      NV_DONE, // ack pulse
   output int        commits  // commits taken
);
   int wait_q;
   always @(posedge CLK)
   begin
      NV_DONE <= 1'b0;
      if (SYS_RST)
      begin
         wait_q  <= 0;
         commits <= 0;
      end
      else if (wait_q == 1)
      begin
         NV_DONE <= 1'b1;
         commits <= commits + 1;
         wait_q  <= 0;
      end
      else if (wait_q > 1)
         wait_q <= wait_q - 1;
      // the request is still up in the cycle after an ack; ignore it there
      else if (NV_REQ && !NV_DONE)
         wait_q <= DELAY;
   end
endmodule : pds_nv_model

// *** test/tb.sv ***
/*
 testbench for the parameter dictionary store: mailbox accesses, channel
 layout, commits and suppression.
 assumes the nonvolatile writer model answers every commit.
*/
`timescale 1ns/1ps
module tb;
   logic        clk = 0, rst = 1, req = 0, wr = 0;
   logic [15:0] idx = '0;
   logic [7:0]  sub = '0;
   logic [31:0] wd = '0, rd, nvd;
   logic [15:0] nvi;
   logic [7:0]  nvs;
   logic        ack, err, nvq, done, supp;
   int          n_fail = 0, cmp_count = 0, commits, base, i;
   always #20 clk = ~clk;
   pds_store #(.CHANNELS(4), .SUBS(4)) dut_u (.CLK(clk), .SYS_RST(rst),
      .MB_REQ(req), .MB_WR(wr), .MB_INDEX(idx), .MB_SUB(sub),
      .MB_WDATA(wd), .MB_ACK(ack), .MB_ERR(err), .MB_RDATA(rd),
      .NV_REQ(nvq), .NV_INDEX(nvi), .NV_SUB(nvs), .NV_DATA(nvd),
      .NV_DONE(done), .NV_SUPPRESS(supp));
   pds_nv_model nv_u (.CLK(clk), .SYS_RST(rst), .NV_REQ(nvq),
      .NV_DONE(done), .commits(commits));
   task chk(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task acc(input logic w, input logic [15:0] x, input logic [7:0] s,
            input logic [31:0] d, input logic e);
      @(posedge clk);
      #1 {req, wr, idx, sub, wd} = {1'b1, w, x, s, d};
      @(posedge clk);
      #1 req = 0;
      chk("ack", ack, 1);
      chk("err", err, e);
      if (!w) chk("rdata", rd, e ? 32'h0000_0000 : d);
   endtask : acc
   // write, then read the same entry in the very next cycle
   task wr_rd(input logic [15:0] x, input logic [7:0] s,
              input logic [31:0] d);
      @(posedge clk);
      #1 {req, wr, idx, sub, wd} = {1'b1, 1'b1, x, s, d};
      @(posedge clk);
      #1 wr = 0;
      chk("ack", ack, 1);
      @(posedge clk);
      #1 req = 0;
      chk("ack", ack, 1);
      chk("rdata", rd, d);
   endtask : wr_rd
   task wait_nv(input logic lvl);
      for (i = 0; i < 30 && nvq !== lvl; i++) @(posedge clk) #1;
      if (nvq !== lvl)
      begin
         chk("nv_req", nvq, lvl);
         tally_and_finish;
      end
   endtask : wait_nv
   task reset;
      rst = 1;
      repeat (16) @(posedge clk);
      #1 rst = 0;
   endtask : reset
   initial
   begin
      reset;
      chk("supp", supp, 0);
      acc(0, 16'h8012, 8'h01, 32'h0000_0000, 0);
      acc(1, 16'h8012, 8'h01, 32'hCAFE_0001, 0);
      acc(0, 16'h8012, 8'h01, 32'hCAFE_0001, 0);
      wait_nv(1);
      chk("nv_idx", {nvi, nvs, 8'h00}, 32'h8012_0100);
      chk("nv_data", nvd, 32'hCAFE_0001);
      for (int c = 0; c < 4; c++)
      begin
         acc(1, 16'h800F | 16'(c << 4), 8'h03, 32'(c + 9), 0);
         acc(0, 16'h800F | 16'(c << 4), 8'h03, 32'(c + 9), 0);
      end
      acc(1, 16'h8040, 8'h00, 32'h0000_0001, 1);
      acc(0, 16'h8040, 8'h00, 32'h0000_0000, 1);
      acc(0, 16'h8000, 8'h04, 32'h0000_0000, 1);
      acc(0, 16'h1018, 8'h00, 32'h0000_0000, 1);
      acc(1, 16'hF008, 8'h01, 32'h1234_5678, 1);
      chk("supp", supp, 0);
      acc(1, 16'hF008, 8'h00, 32'h1234_5678, 0);
      chk("supp", supp, 1);
      acc(0, 16'hF008, 8'h00, 32'h1234_5678, 0);
      repeat (8) @(posedge clk);
      #1;
      wait_nv(0);
      base = commits;
      // repeated runtime writes go only while suppressed
      for (int k = 0; k < 4; k++)
      begin
         acc(1, 16'h8021, 8'h02, 32'(k), 0);
         acc(0, 16'h8021, 8'h02, 32'(k), 0);
      end
      wr_rd(16'h8031, 8'h01, 32'hBEEF_0002);
      repeat (10) @(posedge clk);
      #1;
      chk("commits", commits, base);
      chk("supp", supp, 1);
      acc(1, 16'hF008, 8'h00, 32'h1234_5679, 0);
      chk("supp", supp, 0);
      acc(1, 16'h8021, 8'h02, 32'h0000_0005, 0);
      wait_nv(1);
      chk("nv_data", nvd, 32'h0000_0005);
      chk("nv_idx", {nvi, nvs, 8'h00}, 32'h8021_0200);
      acc(1, 16'hF008, 8'h00, 32'h1234_5678, 0);
      reset;
      chk("supp", supp, 0);
      acc(0, 16'hF008, 8'h00, 32'h0000_0000, 0);
      acc(0, 16'h8012, 8'h01, 32'h0000_0000, 0);
      acc(1, 16'h8012, 8'h01, 32'hCAFE_0001, 0);
      acc(0, 16'h8012, 8'h01, 32'hCAFE_0001, 0);
      wait_nv(1);
      chk("nv_data", nvd, 32'hCAFE_0001);
      tally_and_finish;
   end
endmodule : tb
